//--- bench/exec_model.sv
`timescale 1ns/1ps
`default_nettype none
module exec_model
  import mode_seq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // sequencer side
  input  wire seq_cmd_t   cmd,
  input  wire logic       step_grant,
  output logic            startup_done,
  output logic            startup_error,
  output logic            step_done,
  output logic            bp_hit,
  output logic [1:0]      bp_count,
  output logic            bp_active,
  // bench knobs
  input  wire logic [1:0] bp_n,
  input  wire logic       bp_arm
);
  int su_cnt;
  // startup finishes after 13 cycles, pulses bp_hit in main when armed
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      su_cnt       <= 0;
      startup_done <= 1'b0;
      step_done    <= 1'b0;
      bp_hit       <= 1'b0;
    end else begin
      su_cnt       <= cmd.run_startup ? su_cnt + 1 : 0;
      startup_done <= cmd.run_startup && su_cnt == 12;
      step_done    <= step_grant;
      bp_hit       <= bp_arm && cmd.run_main && !bp_hit;
    end
  end
  assign startup_error = 1'b0;
  assign bp_count      = bp_n;
  assign bp_active     = bp_arm;
endmodule
`default_nettype wire

//--- bench/operating_mode_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module operating_mode_sequencer_bench
  import mode_seq_pkg::*;
;
  logic        clk, arst_n, awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, bready, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rd;
  logic [1:0]  bresp, rresp, mode, bp_n, bp_count, rsp;
  logic        su_done, su_err, st_done, bp_hit, bp_active, bp_arm;
  logic        exec_en, tmr_run, st_grant, st_ref, inh, comm, wdf, cyf;
  logic        saw_ref = 1'b0, saw_grant = 1'b0, seen_ci = 1'b0;
  seq_cmd_t    cmd;
  leds_t       leds;
  int          n_errors, compares, ph, i;
  int          last_ph = 0;
  logic [31:0] exp_mem [16];

  operating_mode_sequencer #(.BLINK_CYCLES(20), .WDOG_CYCLES(50), .FLASH_CYCLES(4)) dut (
    .clk(clk), .arst_n(arst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .startup_done(su_done), .startup_error(su_err), .step_done(st_done),
    .bp_hit(bp_hit), .bp_count(bp_count), .bp_active(bp_active), .cmd(cmd),
    .exec_enable(exec_en), .timers_run(tmr_run), .step_grant(st_grant),
    .step_refused(st_ref), .output_inhibit(inh), .leds(leds), .mode(mode),
    .comm_keep(comm), .wdog_fault(wdf), .cyc_fault(cyf));

  exec_model partner (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .step_grant(st_grant),
    .startup_done(su_done), .startup_error(su_err), .step_done(st_done),
    .bp_hit(bp_hit), .bp_count(bp_count), .bp_active(bp_active),
    .bp_n(bp_n), .bp_arm(bp_arm));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 1000) begin
      chk("timeout", 0, 1);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int  n;
    logic ad, wd;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    {ad, wd, n} = 0;
    while (!(ad && wd)) begin
      tick(n);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) tick(n);
    rsp = bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) tick(n);
    rd  = rdata;
    rsp = rresp;
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode !== m) tick(n);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic blink_seen();
    logic b0, b1;
    {b0, b1} = 0;
    repeat (10) begin
      @(posedge clk);
      if (leds.run_indicator === 1'b0) b0 = 1'b1;
      if (leds.run_indicator === 1'b1) b1 = 1'b1;
    end
    chk("run_blink", 1, b0 & b1);
  endtask

  // phase order monitor
  always @(posedge clk) begin
    if (st_ref === 1'b1) saw_ref <= 1'b1;
    if (st_grant === 1'b1) saw_grant <= 1'b1;
    ph = cmd.read_input_image ? 1 : cmd.run_main ? 2 : cmd.write_output_image ? 3 : 0;
    if (ph != 0 && ph != last_ph && last_ph != 0)
      chk("phase_prev", (ph == 1) ? 3 : ph - 1, last_ph);
    if (cmd.run_startup === 1'b1) chk("clr_in_first", 1, seen_ci);
    if (cmd.clear_input_image === 1'b1) seen_ci <= 1'b1;
    else if (cmd.run_main === 1'b1) seen_ci <= 1'b0;
    if (mode === 2'd3 || arst_n === 1'b0) last_ph <= 0;
    else if (cmd.clear_output_image === 1'b1) last_ph <= 3;
    else if (ph != 0) last_ph <= ph;
  end

  initial begin
    seed = 32'h24;
    {awvalid, wvalid, arvalid, bp_arm} = 0;
    {awaddr, araddr, wdata, bp_n} = 0;
    {bready, rready} = 2'b11;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("mode", 0, mode);
    chk("inhibit", 1, inh);
    chk("leds", 2'b01, leds);
    rdr(OFF_CYCLIM);
    chk("cyclim", CYCLIM_RST, rd);
    rdr(8'h20);
    chk("unmapped", RESP_SLVERR, rsp);
    wr(OFF_STATUS, 32'h0);
    chk("ro_write", RESP_SLVERR, rsp);
    wr(OFF_CYCLIM, 32'h1);
    rdr(OFF_CYCLIM);
    chk("cyclim_min", CYC_MIN_CYC, rd);
    for (i = 0; i < 16; i++) begin
      exp_mem[i] = xs();
      wr(OFF_MEM + 8'(4 * i), exp_mem[i]);
    end
    $display("test registers done");
    bp_n <= 2'd3;
    wr(OFF_CTRL, 32'h1);
    wait_mode(2'd1);
    chk("su_inhibit", 1, inh);
    chk("su_stop", 0, leds.stop_indicator);
    blink_seen();
    wait_mode(2'd2);
    chk("run_inhibit", 0, inh);
    chk("run_stop", 0, leds.stop_indicator);
    chk("run_exec", 2'b11, {exec_en, tmr_run});
    repeat (40) @(posedge clk);
    #1;
    chk("run_indicator", 1, leds.run_indicator);
    $display("test startup done");
    bp_arm <= 1'b1;
    wait_mode(2'd3);
    bp_arm <= 1'b0;
    chk("hold_inhibit", 2'b11, {inh, comm});
    chk("hold_stop", 1, leds.stop_indicator);
    chk("hold_exec", 2'b00, {exec_en, tmr_run});
    blink_seen();
    wr(OFF_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    #1;
    chk("step_refused", 2'b10, {saw_ref, saw_grant});
    bp_n <= 2'd2;
    wr(OFF_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    #1;
    chk("step_grant", 1, saw_grant);
    chk("step_mode", 3, mode);
    wr(OFF_CTRL, 32'h9);
    wait_mode(2'd2);
    chk("resume_inhibit", 0, inh);
    $display("test hold done");
    repeat (xs() % 8) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    wait_mode(2'd0);
    chk("stop_inhibit", 1, inh);
    chk("stop_leds", 2'b01, leds);
    chk("stop_exec", 0, exec_en);
    rdr(OFF_STATUS);
    chk("status_mode", 0, rd[1:0]);
    chk("faults", 2'b00, {wdf, cyf});
    for (i = 0; i < 16; i++) begin
      rdr(OFF_MEM + 8'(4 * i));
      chk("mem_kept", exp_mem[i], rd);
    end
    wr(OFF_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    for (i = 0; i < 16; i++) begin
      rdr(OFF_MEM + 8'(4 * i));
      chk("mem_erased", 0, rd);
    end
    $display("test stop and erase done");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- common/mode_seq_pkg.sv
// Contract
// - always exactly one of four modes
// - stop: no program, outputs off, stop lit
// - entering stop keeps images and timers
// - stop to run calls unsupervised startup
// - startup: outputs inhibited, stop indicator off
// - run indicator blinks at least 3 s
// - startup complete enters run
// - run: timers active, image refreshed per cycle
// - run: outputs enabled, run lit, stop dark
// - at most three breakpoints defined
// - reaching active breakpoint enters hold
// - hold: execution halted, timers frozen, clock runs
// - hold: outputs inhibited, links kept alive
// - hold: run blinks, stop steady
// - no single step above two breakpoints
// - watchdog 100 ms, cycle limit down to 1 ms
// - run to stop inhibits outputs, safe analog (code only raises output_inhibit; ao_kind_t is unused)
// - start: clear inputs, startup, release, first cycle
// - cycle order: read inputs, main, write outputs
// - overall reset erases user memory only
package mode_seq_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned BLINK_MS      = 3000;
  localparam int unsigned WDOG_MS       = 100;
  localparam int unsigned CYC_MIN_MS    = 1;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned BLINK_CYC     = BLINK_MS * CYC_PER_MS;
  localparam int unsigned WDOG_CYC      = WDOG_MS * CYC_PER_MS;
  localparam int unsigned CYC_MIN_CYC   = CYC_MIN_MS * CYC_PER_MS;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_CYC     = FLASH_HALF_MS * CYC_PER_MS;
  localparam int unsigned BP_MAX        = 3;
  localparam int unsigned BP_STEP_MAX   = 2;
  localparam int unsigned MEM_WORDS     = 16;
  // register map
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CYCLIM = 8'h08;
  localparam logic [7:0] OFF_BP     = 8'h0c;
  localparam logic [7:0] OFF_MEM    = 8'h40;
  // ctrl bits
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_ERASE = 1;
  localparam int unsigned CTRL_STEP  = 2;
  localparam int unsigned CTRL_RESUME = 3;
  localparam int unsigned CTRL_FLTCLR = 4;
  localparam logic [31:0] CYCLIM_RST = 32'd2_000_000;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    AO_VOLT,
    AO_I020,
    AO_I420
  } ao_kind_t;
  typedef struct packed {
    logic run_indicator;
    logic stop_indicator;
  } leds_t;
  typedef struct packed {
    logic clear_input_image;
    logic clear_output_image;
    logic read_input_image;
    logic run_main;
    logic write_output_image;
    logic run_startup;
  } seq_cmd_t;
endpackage

//--- hdl/operating_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module operating_mode_sequencer
  import mode_seq_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned WDOG_CYCLES  = WDOG_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output var  logic        s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output var  logic        s_wready,
  output var  logic [1:0]  s_bresp,
  output var  logic        s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output var  logic        s_arready,
  output var  logic [31:0] s_rdata,
  output var  logic [1:0]  s_rresp,
  output var  logic        s_rvalid,
  input  wire logic        s_rready,
  // program executor handshake
  input  wire logic        startup_done,
  input  wire logic        startup_error,
  input  wire logic        step_done,
  input  wire logic        bp_hit,
  input  wire logic [1:0]  bp_count,
  input  wire logic        bp_active,
  output var  seq_cmd_t    cmd,
  output var  logic        exec_enable,
  output var  logic        timers_run,
  output var  logic        step_grant,
  output var  logic        step_refused,
  // outputs and indicators
  output var  logic        output_inhibit,
  output var  leds_t       leds,
  output var  logic [1:0]  mode,
  output var  logic        comm_keep,
  output var  logic        wdog_fault,
  output var  logic        cyc_fault
);
  typedef enum logic [1:0] {M_STOP, M_STARTUP, M_RUN, M_HOLD} mode_t;
  typedef enum logic [2:0] {
    P_IDLE, P_CLR_IN, P_STARTUP, P_CLR_OUT, P_READ, P_MAIN, P_WRITE
  } phase_t;

  function automatic logic is_word(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // user memory window only, no alias above it
  function automatic logic is_mem(input logic [7:0] a);
    return a[7:6] == OFF_MEM[7:6];
  endfunction

  mode_t            st;
  phase_t           ph;
  logic             run_req;
  logic [31:0]      cyc_limit;
  logic [31:0]      wdog_cnt;
  logic [31:0]      cyc_cnt;
  logic [31:0]      blink_cnt;
  logic [31:0]      flash_cnt;
  logic             flash;
  logic [31:0]      user_mem [MEM_WORDS];
  logic             aw_hold;
  logic             w_hold;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic             wr_go;
  logic             erase_pulse;
  logic             step_pulse;
  logic             resume_pulse;
  logic             fltclr_pulse;
  logic             fault;
  logic             blinking;

  assign fault = wdog_fault | cyc_fault;
  assign wr_go = aw_hold & w_hold & ~s_bvalid;
  assign blinking = (blink_cnt != 32'd0);

  // axi write channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OK;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_data <= s_wdata;
      end
      if (wr_go) begin
        aw_hold  <= 1'b0;
        w_hold   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (is_word(aw_addr, OFF_CTRL) || is_word(aw_addr, OFF_CYCLIM) ||
                     is_mem(aw_addr)) ? RESP_OK : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= ~aw_hold & ~(s_awvalid & s_awready) & ~s_bvalid;
      s_wready  <= ~w_hold & ~(s_wvalid & s_wready) & ~s_bvalid;
    end
  end

  // control register and pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_req      <= 1'b0;
      cyc_limit    <= CYCLIM_RST;
      erase_pulse  <= 1'b0;
      step_pulse   <= 1'b0;
      resume_pulse <= 1'b0;
      fltclr_pulse <= 1'b0;
    end else begin
      erase_pulse  <= 1'b0;
      step_pulse   <= 1'b0;
      resume_pulse <= 1'b0;
      fltclr_pulse <= 1'b0;
      if (wr_go && is_word(aw_addr, OFF_CTRL)) begin
        run_req      <= w_data[CTRL_RUN];
        erase_pulse  <= w_data[CTRL_ERASE];
        step_pulse   <= w_data[CTRL_STEP];
        resume_pulse <= w_data[CTRL_RESUME];
        fltclr_pulse <= w_data[CTRL_FLTCLR];
      end
      if (wr_go && is_word(aw_addr, OFF_CYCLIM)) begin
        cyc_limit <= (w_data < CYC_MIN_CYC) ? CYC_MIN_CYC : w_data;
      end
    end
  end

  // user memory, erased by overall reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_WORDS; i++) user_mem[i] <= 32'h0;
    end else if (erase_pulse && st == M_STOP) begin
      for (int i = 0; i < MEM_WORDS; i++) user_mem[i] <= 32'h0;
    end else if (wr_go && is_mem(aw_addr)) begin
      user_mem[aw_addr[5:2]] <= w_data;
    end
  end

  // axi read channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= RESP_OK;
    end else begin
      s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= RESP_OK;
        if (is_word(s_araddr, OFF_CTRL)) s_rdata <= {31'h0, run_req};
        else if (is_word(s_araddr, OFF_STATUS))
          s_rdata <= {24'h0, step_refused, cyc_fault, wdog_fault, blinking,
                      output_inhibit, ph == P_IDLE, mode};
        else if (is_word(s_araddr, OFF_CYCLIM)) s_rdata <= cyc_limit;
        else if (is_word(s_araddr, OFF_BP)) s_rdata <= {29'h0, bp_active, bp_count};
        else if (is_mem(s_araddr)) s_rdata <= user_mem[s_araddr[5:2]];
        else begin
          s_rdata <= 32'h0;
          s_rresp <= RESP_SLVERR;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // mode and phase sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= M_STOP;
      ph <= P_IDLE;
    end else begin
      unique case (st)
        M_STOP: begin
          ph <= P_IDLE;
          if (run_req && !fault) begin
            st <= M_STARTUP;
            ph <= P_CLR_IN;
          end
        end
        M_STARTUP: begin
          if (!run_req || startup_error) begin
            st <= M_STOP;
            ph <= P_IDLE;
          end else if (ph == P_CLR_IN) ph <= P_STARTUP;
          else if (startup_done) begin
            st <= M_RUN;
            ph <= P_CLR_OUT;
          end
        end
        M_RUN: begin
          if (!run_req || fault) begin
            st <= M_STOP;
            ph <= P_IDLE;
          end else if (bp_hit && bp_active) st <= M_HOLD;
          else begin
            unique case (ph)
              P_CLR_OUT: ph <= P_READ;
              P_READ:    ph <= P_MAIN;
              P_MAIN:    ph <= P_WRITE;
              default:   ph <= P_READ;
            endcase
          end
        end
        M_HOLD: begin
          if (!run_req) begin
            st <= M_STOP;
            ph <= P_IDLE;
          end else if (resume_pulse) st <= M_RUN;
          else if (step_done && ph == P_MAIN) ph <= P_WRITE;
        end
      endcase
    end
  end

  // single step gate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_grant   <= 1'b0;
      step_refused <= 1'b0;
    end else begin
      step_grant   <= step_pulse && st == M_HOLD && bp_count <= BP_STEP_MAX;
      step_refused <= step_pulse && (st != M_HOLD || bp_count > BP_STEP_MAX);
    end
  end

  // watchdog and cycle time supervision
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_cnt   <= 32'h0;
      cyc_cnt    <= 32'h0;
      wdog_fault <= 1'b0;
      cyc_fault  <= 1'b0;
    end else begin
      if (st != M_RUN || ph == P_READ) begin
        wdog_cnt <= 32'h0;
        cyc_cnt  <= 32'h0;
      end else begin
        wdog_cnt <= wdog_cnt + 32'd1;
        cyc_cnt  <= cyc_cnt + 32'd1;
      end
      if (st == M_RUN && wdog_cnt >= WDOG_CYCLES - 1) wdog_fault <= 1'b1;
      else if (fltclr_pulse) wdog_fault <= 1'b0;
      if (st == M_RUN && cyc_cnt >= cyc_limit - 32'd1) cyc_fault <= 1'b1;
      else if (fltclr_pulse) cyc_fault <= 1'b0;
    end
  end

  // start-up blink hold and flash clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt <= 32'h0;
      flash_cnt <= 32'h0;
      flash     <= 1'b0;
    end else begin
      if (st == M_STARTUP && ph == P_STARTUP && blink_cnt == 32'h0 && !blinking)
        blink_cnt <= BLINK_CYCLES;
      else if (blinking) blink_cnt <= blink_cnt - 32'd1;
      if (flash_cnt >= FLASH_CYCLES - 1) begin
        flash_cnt <= 32'h0;
        flash     <= ~flash;
      end else flash_cnt <= flash_cnt + 32'd1;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_inhibit <= 1'b1;
      leds           <= '{run_indicator: 1'b0, stop_indicator: 1'b1};
      mode           <= 2'h0;
      exec_enable    <= 1'b0;
      timers_run     <= 1'b0;
      comm_keep      <= 1'b1;
      cmd            <= '0;
    end else begin
      mode           <= st;
      output_inhibit <= (st != M_RUN);
      exec_enable    <= (st == M_RUN) || (st == M_STARTUP) ||
                        (step_grant && st == M_HOLD);
      timers_run     <= (st == M_RUN);
      comm_keep      <= 1'b1;
      leds.stop_indicator <= (st == M_STOP) || (st == M_HOLD);
      leds.run_indicator  <= (st == M_RUN && !blinking) ||
                             ((st == M_HOLD || blinking) && flash);
      cmd.clear_input_image  <= (ph == P_CLR_IN);
      cmd.run_startup        <= (ph == P_STARTUP);
      cmd.clear_output_image <= (ph == P_CLR_OUT);
      cmd.read_input_image   <= (ph == P_READ) && st == M_RUN;
      cmd.run_main           <= (ph == P_MAIN) && st == M_RUN;
      cmd.write_output_image <= (ph == P_WRITE) && st == M_RUN;
    end
  end

  // checks
  property p_stop_inhibit;
    @(posedge clk) disable iff (!arst_n) st == M_STOP |=> output_inhibit && !exec_enable;
  endproperty
  a_stop_inhibit: assert property (p_stop_inhibit) else $error("stop not inhibited");

  property p_startup_leds;
    @(posedge clk) disable iff (!arst_n) st == M_STARTUP |=> output_inhibit && !leds.stop_indicator;
  endproperty
  a_startup_leds: assert property (p_startup_leds) else $error("startup outputs");

  property p_blink_len;
    @(posedge clk) disable iff (!arst_n) $rose(blinking) |-> blinking [*8];
  endproperty
  a_blink_len: assert property (p_blink_len) else $error("blink too short");

  property p_run_out;
    @(posedge clk) disable iff (!arst_n) st == M_RUN |=> !output_inhibit && !leds.stop_indicator;
  endproperty
  a_run_out: assert property (p_run_out) else $error("run outputs");

  property p_bp_hold;
    @(posedge clk) disable iff (!arst_n)
      st == M_RUN && run_req && !fault && bp_hit && bp_active |=> st == M_HOLD;
  endproperty
  a_bp_hold: assert property (p_bp_hold) else $error("no hold on breakpoint");

  property p_hold_out;
    @(posedge clk) disable iff (!arst_n)
      st == M_HOLD |=> output_inhibit && leds.stop_indicator && !timers_run && comm_keep;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("hold outputs");

  property p_step_ref;
    @(posedge clk) disable iff (!arst_n) step_pulse && bp_count > BP_STEP_MAX |=> !step_grant;
  endproperty
  a_step_ref: assert property (p_step_ref) else $error("step granted");

  property p_fault_stop;
    @(posedge clk) disable iff (!arst_n) st == M_RUN && fault |=> st == M_STOP;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault kept running");

  sequence s_adv;
    st == M_RUN && run_req && !fault && !(bp_hit && bp_active);
  endsequence
  sequence s_cycle;
    ph == P_MAIN ##1 ph == P_WRITE;
  endsequence
  property p_order;
    @(posedge clk) disable iff (!arst_n)
      ph == P_READ ##0 s_adv ##1 s_adv |-> s_cycle;
  endproperty
  a_order: assert property (p_order) else $error("cycle order");

  property p_start_seq;
    @(posedge clk) disable iff (!arst_n)
      st == M_STOP && run_req && !fault |=> ph == P_CLR_IN ##1 (ph == P_STARTUP || st == M_STOP);
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("start sequence");
endmodule
`default_nettype wire
